// ==== verilog/cafm_pkg.sv ====
// package: constants and carrier types of the acceptance filter match block
package cafm_pkg;

   // sizes
   localparam int NUM_FILTERS = 16;
   localparam int NUM_MASKS = 3;
   localparam int SEL_FIELD_W = 2;
   localparam int PTR_FIELD_W = 4;
   localparam int FILTERS_PER_SEL = 8;
   localparam int FILTERS_PER_PTR = 4;
   localparam int NUM_PTR_REGS = 4;

   // register byte offsets
   localparam logic [7:0] OFS_FILT_STD = 8'h00;
   localparam logic [7:0] OFS_FILT_EXT = 8'h40;
   localparam logic [7:0] OFS_MASK_STD = 8'h80;
   localparam logic [7:0] OFS_MASK_EXT = 8'h90;
   localparam logic [7:0] OFS_MSKSEL_LOW = 8'hA0;
   localparam logic [7:0] OFS_MSKSEL_HIGH = 8'hA4;
   localparam logic [7:0] OFS_FLT_ENABLE = 8'hA8;
   localparam logic [7:0] OFS_BUF_PTR = 8'hB0;
   localparam logic [7:0] OFS_STATUS = 8'hC0;

   // field positions in the standard identifier registers
   localparam int STD_IDENT_MSB = 15;
   localparam int STD_IDENT_LSB = 5;
   localparam int FRAME_TYPE_BIT = 3;
   localparam int EXT_HIGH_MSB = 1;
   localparam int EXT_HIGH_LSB = 0;
   localparam logic [15:0] STD_REG_IMPL_MASK = 16'hFFEB;

   // status register fields
   localparam int STAT_HIT_BIT = 0;
   localparam int STAT_INDEX_LSB = 4;
   localparam int STAT_PTR_LSB = 8;

   // mask source code meaning no mask
   localparam logic [1:0] MASK_NONE = 2'h3;

   // reset values
   localparam logic [15:0] ID_REG_RESET = 16'h0000;
   localparam logic [15:0] MSKSEL_RESET = 16'h0000;
   localparam logic [15:0] FLT_ENABLE_RESET = 16'hFFFF;
   localparam logic [15:0] BUF_PTR_RESET = 16'h0000;

   typedef enum logic {BUS_IDLE, BUS_ANSWER} cafm_bus_type;

   // identifier offered by the receive protocol engine
   typedef struct packed {
      logic valid;
      logic extFrame;
      logic [10:0] stdIdent;
      logic [17:0] extIdent;
   } cafm_id_type;

   // registered match result
   typedef struct packed {
      logic valid;
      logic hit;
      logic [3:0] index;
      logic [3:0] bufPtr;
   } cafm_result_type;

   // a standard/extended register pair of a filter or a mask
   typedef struct packed {
      logic [15:0] stdReg;
      logic [15:0] extReg;
   } cafm_idregs_type;

endpackage : cafm_pkg

// ==== verilog/cafm_filter_cmp.sv ====
// module: compares one received identifier against one filter and its mask
`timescale 1ns/1ns
`default_nettype none
module cafm_filter_cmp
(
   // identifier
   input wire cafm_pkg::cafm_id_type idIn,
   // filter and selected mask
   input wire cafm_pkg::cafm_idregs_type filt,
   input wire cafm_pkg::cafm_idregs_type mask,
   input wire logic noMask,
   // result
   output logic rawHit
);
   logic [10:0] careStd;
   logic [17:0] careExt;
   logic typeCheck;
   logic stdOk;
   logic extOk;
   logic typeOk;

   // no mask compares every bit and the frame type
   assign careStd = noMask ? 11'h7FF
      : mask.stdReg[cafm_pkg::STD_IDENT_MSB:cafm_pkg::STD_IDENT_LSB];
   assign careExt = noMask ? 18'h3FFFF
      : {mask.stdReg[cafm_pkg::EXT_HIGH_MSB:cafm_pkg::EXT_HIGH_LSB], mask.extReg};
   assign typeCheck = noMask | mask.stdReg[cafm_pkg::FRAME_TYPE_BIT];

   assign stdOk = ((idIn.stdIdent
      ^ filt.stdReg[cafm_pkg::STD_IDENT_MSB:cafm_pkg::STD_IDENT_LSB]) & careStd) == 11'h000;
   // standard frames carry no extended bits
   assign extOk = !idIn.extFrame || (((idIn.extIdent
      ^ {filt.stdReg[cafm_pkg::EXT_HIGH_MSB:cafm_pkg::EXT_HIGH_LSB], filt.extReg})
      & careExt) == 18'h00000);
   assign typeOk = !typeCheck
      || (idIn.extFrame == filt.stdReg[cafm_pkg::FRAME_TYPE_BIT]);

   assign rawHit = idIn.valid & stdOk & extOk & typeOk;

endmodule : cafm_filter_cmp
`default_nettype wire

// ==== verilog/cafm_accept_filter.sv ====
// module: acceptance filter bank with Avalon-MM register slave
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module cafm_accept_filter
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [7:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   // identifier from the receive engine
   input wire cafm_pkg::cafm_id_type idIn,
   // match result
   output cafm_pkg::cafm_result_type result
);
   // register storage
   logic [15:0] filtStd_r [cafm_pkg::NUM_FILTERS];
   logic [15:0] filtExt_r [cafm_pkg::NUM_FILTERS];
   logic [15:0] maskStd_r [cafm_pkg::NUM_MASKS];
   logic [15:0] maskExt_r [cafm_pkg::NUM_MASKS];
   logic [31:0] mskSel_r;
   logic [15:0] fltEn_r;
   logic [63:0] bufPtr_r;
   cafm_pkg::cafm_result_type result_r;
   logic [15:0] status_r;
   cafm_pkg::cafm_bus_type busState_r;
   logic [31:0] readData_r;
   logic waitReq_r;

   // match and bus signals
   logic [15:0] rawHits;
   logic [15:0] hits;
   logic [4:0] firstHit;
   logic writeNow;
   logic [15:0] readWord;

   // mask source field of filter n
   function automatic logic [1:0] maskSrc(input logic [31:0] sel, input int n);
      maskSrc = sel[n * cafm_pkg::SEL_FIELD_W +: cafm_pkg::SEL_FIELD_W];
   endfunction : maskSrc

   // buffer pointer field of filter n
   function automatic logic [3:0] ptrOf(input logic [63:0] ptrs, input logic [3:0] n);
      ptrOf = ptrs[n * cafm_pkg::PTR_FIELD_W +: cafm_pkg::PTR_FIELD_W];
   endfunction : ptrOf

   // byte-enable merge into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
      input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge16

   // lowest set bit: {found, index}
   function automatic logic [4:0] lowestSet(input logic [15:0] v);
      lowestSet = 5'h00;
      for (int k = cafm_pkg::NUM_FILTERS - 1; k >= 0; k--)
      begin
         if (v[k])
         begin
            lowestSet = {1'b1, 4'(k)};
         end
      end
   endfunction : lowestSet

   // per-filter mask selection and compare
   genvar gi;
   generate
      for (gi = 0; gi < cafm_pkg::NUM_FILTERS; gi++)
      begin : gFilter
         logic [1:0] src;
         logic noMask;
         cafm_pkg::cafm_idregs_type filtPair;
         cafm_pkg::cafm_idregs_type maskPair;
         assign src = maskSrc(mskSel_r, gi);
         assign noMask = (src == cafm_pkg::MASK_NONE);
         assign filtPair = {filtStd_r[gi], filtExt_r[gi]};
         assign maskPair = noMask ? 32'h0000_0000 : {maskStd_r[src], maskExt_r[src]};
         cafm_filter_cmp uCmp
         (
            .idIn(idIn),
            .filt(filtPair),
            .mask(maskPair),
            .noMask(noMask),
            .rawHit(rawHits[gi])
         );
         AST_FRAME_TYPE: assert property (@(posedge ref_clk) disable iff (!nrst)
            rawHits[gi] && (noMask || maskPair.stdReg[cafm_pkg::FRAME_TYPE_BIT])
            |-> idIn.extFrame == filtPair.stdReg[cafm_pkg::FRAME_TYPE_BIT])
            else $error("filter hit on the wrong frame type");
         AST_MODE0_IGNORES_TYPE: assert property (@(posedge ref_clk) disable iff (!nrst)
            idIn.valid && !noMask && !maskPair.stdReg[cafm_pkg::FRAME_TYPE_BIT]
            && (((idIn.stdIdent ^ filtPair.stdReg[15:5]) & maskPair.stdReg[15:5]) == 11'h000)
            && (!idIn.extFrame || (((idIn.extIdent ^ {filtPair.stdReg[1:0], filtPair.extReg})
            & {maskPair.stdReg[1:0], maskPair.extReg}) == 18'h00000))
            |-> rawHits[gi])
            else $error("mode 0 filter missed a matching identifier");
         AST_CARED_BITS_EQUAL: assert property (@(posedge ref_clk) disable iff (!nrst)
            rawHits[gi] && !noMask
            |-> ((idIn.stdIdent ^ filtPair.stdReg[15:5]) & maskPair.stdReg[15:5]) == 11'h000)
            else $error("hit despite a compared standard bit differing");
         AST_UNIMPL_ZERO: assert property (@(posedge ref_clk) disable iff (!nrst)
            filtStd_r[gi][4] == 1'b0 && filtStd_r[gi][2] == 1'b0)
            else $error("unimplemented filter bit holds a one");
      end
   endgenerate

   assign hits = rawHits & fltEn_r;
   assign firstHit = lowestSet(hits);

   // match result register
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         result_r <= '0;
      end
      else
      begin
         result_r.valid <= idIn.valid;
         result_r.hit <= idIn.valid & firstHit[4];
         result_r.index <= firstHit[3:0];
         result_r.bufPtr <= ptrOf(bufPtr_r, firstHit[3:0]);
      end
   end

   assign result = result_r;

   // status keeps the latest finished comparison
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         status_r <= 16'h0000;
      end
      else if (result_r.valid)
      begin
         status_r <= 16'h0000;
         status_r[cafm_pkg::STAT_HIT_BIT] <= result_r.hit;
         status_r[cafm_pkg::STAT_INDEX_LSB +: 4] <= result_r.index;
         status_r[cafm_pkg::STAT_PTR_LSB +: 4] <= result_r.bufPtr;
      end
   end

   // bus handshake: one wait cycle, then the answer edge
   assign writeNow = avsWrite && (busState_r == cafm_pkg::BUS_ANSWER);

   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         busState_r <= cafm_pkg::BUS_IDLE;
         waitReq_r <= 1'b1;
         readData_r <= 32'h0000_0000;
      end
      else
      begin
         unique case (busState_r)
            cafm_pkg::BUS_IDLE:
            begin
               if (avsRead || avsWrite)
               begin
                  busState_r <= cafm_pkg::BUS_ANSWER;
                  waitReq_r <= 1'b0;
                  readData_r <= {16'h0000, readWord};
               end
            end
            cafm_pkg::BUS_ANSWER:
            begin
               busState_r <= cafm_pkg::BUS_IDLE;
               waitReq_r <= 1'b1;
            end
         endcase
      end
   end

   assign avsReaddata = readData_r;
   assign avsWaitrequest = waitReq_r;

   // read decode; unmapped addresses read zero
   always_comb
   begin
      readWord = 16'h0000;
      if (avsAddress < cafm_pkg::OFS_FILT_EXT)
      begin
         readWord = filtStd_r[avsAddress[5:2]];
      end
      else if (avsAddress < cafm_pkg::OFS_MASK_STD)
      begin
         readWord = filtExt_r[avsAddress[5:2]];
      end
      else if (avsAddress < cafm_pkg::OFS_MASK_EXT && avsAddress[3:2] != 2'h3)
      begin
         readWord = maskStd_r[avsAddress[3:2]];
      end
      else if (avsAddress >= cafm_pkg::OFS_MASK_EXT && avsAddress < cafm_pkg::OFS_MSKSEL_LOW
         && avsAddress[3:2] != 2'h3)
      begin
         readWord = maskExt_r[avsAddress[3:2]];
      end
      else if (avsAddress == cafm_pkg::OFS_MSKSEL_LOW)
      begin
         readWord = mskSel_r[15:0];
      end
      else if (avsAddress == cafm_pkg::OFS_MSKSEL_HIGH)
      begin
         readWord = mskSel_r[31:16];
      end
      else if (avsAddress == cafm_pkg::OFS_FLT_ENABLE)
      begin
         readWord = fltEn_r;
      end
      else if (avsAddress >= cafm_pkg::OFS_BUF_PTR && avsAddress < cafm_pkg::OFS_STATUS)
      begin
         readWord = bufPtr_r[avsAddress[3:2] * 16 +: 16];
      end
      else if (avsAddress == cafm_pkg::OFS_STATUS)
      begin
         readWord = status_r;
      end
   end

   // filter and mask identifier registers
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         for (int k = 0; k < cafm_pkg::NUM_FILTERS; k++)
         begin
            filtStd_r[k] <= cafm_pkg::ID_REG_RESET;
            filtExt_r[k] <= cafm_pkg::ID_REG_RESET;
         end
         for (int k = 0; k < cafm_pkg::NUM_MASKS; k++)
         begin
            maskStd_r[k] <= cafm_pkg::ID_REG_RESET;
            maskExt_r[k] <= cafm_pkg::ID_REG_RESET;
         end
      end
      else if (writeNow)
      begin
         if (avsAddress < cafm_pkg::OFS_FILT_EXT)
         begin
            filtStd_r[avsAddress[5:2]] <= merge16(filtStd_r[avsAddress[5:2]], avsWritedata,
               avsByteenable) & cafm_pkg::STD_REG_IMPL_MASK;
         end
         else if (avsAddress < cafm_pkg::OFS_MASK_STD)
         begin
            filtExt_r[avsAddress[5:2]] <= merge16(filtExt_r[avsAddress[5:2]], avsWritedata,
               avsByteenable);
         end
         else if (avsAddress < cafm_pkg::OFS_MASK_EXT && avsAddress[3:2] != 2'h3)
         begin
            maskStd_r[avsAddress[3:2]] <= merge16(maskStd_r[avsAddress[3:2]], avsWritedata,
               avsByteenable) & cafm_pkg::STD_REG_IMPL_MASK;
         end
         else if (avsAddress >= cafm_pkg::OFS_MASK_EXT && avsAddress < cafm_pkg::OFS_MSKSEL_LOW
            && avsAddress[3:2] != 2'h3)
         begin
            maskExt_r[avsAddress[3:2]] <= merge16(maskExt_r[avsAddress[3:2]], avsWritedata,
               avsByteenable);
         end
      end
   end

   // mask select, enable and buffer pointer registers
   always_ff @(posedge ref_clk)
   begin
      if (!nrst)
      begin
         mskSel_r <= {cafm_pkg::MSKSEL_RESET, cafm_pkg::MSKSEL_RESET};
         fltEn_r <= cafm_pkg::FLT_ENABLE_RESET;
         bufPtr_r <= {4{cafm_pkg::BUF_PTR_RESET}};
      end
      else if (writeNow)
      begin
         if (avsAddress == cafm_pkg::OFS_MSKSEL_LOW)
         begin
            mskSel_r[15:0] <= merge16(mskSel_r[15:0], avsWritedata, avsByteenable);
         end
         else if (avsAddress == cafm_pkg::OFS_MSKSEL_HIGH)
         begin
            mskSel_r[31:16] <= merge16(mskSel_r[31:16], avsWritedata, avsByteenable);
         end
         else if (avsAddress == cafm_pkg::OFS_FLT_ENABLE)
         begin
            fltEn_r <= merge16(fltEn_r, avsWritedata, avsByteenable);
         end
         else if (avsAddress >= cafm_pkg::OFS_BUF_PTR && avsAddress < cafm_pkg::OFS_STATUS)
         begin
            bufPtr_r[avsAddress[3:2] * 16 +: 16] <= merge16(bufPtr_r[avsAddress[3:2] * 16 +: 16],
               avsWritedata, avsByteenable);
         end
      end
   end

   // checking helpers
   logic [15:0] prevHits_r;
   logic [15:0] prevEn_r;
   logic [63:0] prevPtr_r;
   always_ff @(posedge ref_clk)
   begin
      prevHits_r <= rawHits;
      prevEn_r <= fltEn_r;
      prevPtr_r <= bufPtr_r;
   end

   sequence seqBusRequest;
      (avsRead || avsWrite) && waitReq_r && busState_r == cafm_pkg::BUS_IDLE;
   endsequence

   sequence seqBusAnswer;
      !waitReq_r ##1 waitReq_r;
   endsequence

   AST_BUS_ONE_WAIT: assert property (@(posedge ref_clk) disable iff (!nrst)
      seqBusRequest |=> seqBusAnswer)
      else $error("bus answer not given after exactly one wait cycle");

   AST_RESULT_LATENCY: assert property (@(posedge ref_clk) disable iff (!nrst)
      idIn.valid |=> result_r.valid ##1 (result_r.valid == $past(idIn.valid)))
      else $error("result valid not one cycle after the identifier");

   AST_DISABLED_NO_HIT: assert property (@(posedge ref_clk) disable iff (!nrst)
      result_r.hit |-> prevEn_r[result_r.index] && prevHits_r[result_r.index])
      else $error("hit reported for a disabled or non-matching filter");

   AST_LOWEST_WINS: assert property (@(posedge ref_clk) disable iff (!nrst)
      result_r.hit |-> ((prevHits_r & prevEn_r & ((16'h0001 << result_r.index) - 16'h0001))
      == 16'h0000))
      else $error("a lower enabled filter also hit");

   AST_BUF_POINTER: assert property (@(posedge ref_clk) disable iff (!nrst)
      result_r.hit |-> result_r.bufPtr == ptrOf(prevPtr_r, result_r.index))
      else $error("buffer pointer does not belong to the hit filter");

   AST_MSKSEL_WRITE: assert property (@(posedge ref_clk) disable iff (!nrst)
      writeNow && avsAddress == cafm_pkg::OFS_MSKSEL_LOW && avsByteenable[1:0] == 2'h3
      |=> mskSel_r[15:0] == $past(avsWritedata[15:0]))
      else $error("mask select write not stored");

endmodule : cafm_accept_filter
`default_nettype wire

// ==== tb/cafm_rx_engine.sv ====
// model: receive protocol engine offering identifiers to the filter bank
`timescale 1ns/1ns
`default_nettype none
module cafm_rx_engine
(
   // clock
   input wire logic ref_clk,
   // identifier to the filter bank
   output var cafm_pkg::cafm_id_type idIn
);
   initial idIn = '0;

   // one identifier per call, held valid until the next offer or quiet call
   task offer(input logic ext, input logic [10:0] std, input logic [17:0] acceptance_filter_ext_id);
      @(posedge ref_clk);
      idIn <= {1'b1, ext, std, acceptance_filter_ext_id};
   endtask : offer

   // between frames the fields flip so a stale identifier never reads as fresh
   task quiet;
      @(posedge ref_clk);
      idIn <= {1'b0, ~idIn.extFrame, ~idIn.stdIdent, ~idIn.extIdent};
   endtask : quiet
endmodule : cafm_rx_engine
`default_nettype wire

// ==== tb/cafm_accept_filter_bench.sv ====
// testbench: register access and identifier matching of the acceptance filter bank
`timescale 1ns/1ns
`default_nettype none
module cafm_accept_filter_bench;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] avsAddress = 8'h00;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h00000000;
   logic [3:0] avsByteenable = 4'h0;
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   cafm_pkg::cafm_id_type idIn;
   cafm_pkg::cafm_result_type result;
   int failures = 0;
   int checked = 0;
   logic [31:0] rd;

   always #10 ref_clk = ~ref_clk;

   cafm_accept_filter u_dut (.ref_clk(ref_clk), .nrst(nrst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsByteenable(avsByteenable), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest), .idIn(idIn), .result(result));

   cafm_rx_engine u_eng (.ref_clk(ref_clk), .idIn(idIn));

   task results;
      if (failures == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task doReset;
      @(posedge ref_clk);
      nrst <= 1'b0;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
   endtask : doReset

   // request held until waitrequest is seen low at a rising edge
   task busCycle(input logic wr, input logic [7:0] addr, input logic [15:0] data,
      input logic [3:0] be);
      logic done;
      done = 1'b0;
      @(posedge ref_clk);
      avsAddress <= addr;
      avsRead <= ~wr;
      avsWrite <= wr;
      avsWritedata <= {16'h0000, data};
      avsByteenable <= be;
      for (int i = 0; i < 20 && !done; i++)
      begin
         @(posedge ref_clk);
         done = (avsWaitrequest === 1'b0);
      end
      rd = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      if (!done)
      begin
         failures++;
         $display("[ERR] %0t bus answer missing", $time);
         results();
      end
   endtask : busCycle

   task wr(input logic [7:0] addr, input logic [15:0] data);
      busCycle(1'b1, addr, data, 4'h3);
   endtask : wr

   task rdChk(input logic [7:0] addr, input logic [15:0] exp);
      busCycle(1'b0, addr, 16'h0000, 4'h3);
      cmp(rd[15:0], exp);
      cmp(rd[31:16], 16'h0000);
   endtask : rdChk

   task res(input logic hit, input logic [3:0] idx, input logic [3:0] ptr);
      @(negedge ref_clk);
      cmp({6'h00, result}, {6'h00, 1'b1, hit, idx, ptr});
   endtask : res

   task send(input logic ext, input logic [10:0] std, input logic [17:0] acceptance_filter_ext_id,
      input logic hit, input logic [3:0] idx, input logic [3:0] ptr);
      u_eng.offer(ext, std, acceptance_filter_ext_id);
      u_eng.quiet();
      res(hit, idx, ptr);
   endtask : send

   task checkReset;
      rdChk(cafm_pkg::OFS_FILT_STD + 8'h3C, 16'h0000);
      rdChk(cafm_pkg::OFS_MASK_EXT + 8'h08, 16'h0000);
      rdChk(cafm_pkg::OFS_MSKSEL_LOW, 16'h0000);
      rdChk(cafm_pkg::OFS_MSKSEL_HIGH, 16'h0000);
      rdChk(cafm_pkg::OFS_FLT_ENABLE, 16'hFFFF);
      wr(cafm_pkg::OFS_MASK_STD + 8'h0C, 16'hFFFF);
      rdChk(cafm_pkg::OFS_MASK_STD + 8'h0C, 16'h0000);
   endtask : checkReset

   task checkFields;
      wr(cafm_pkg::OFS_FILT_STD + 8'h14, 16'hFFFF);
      rdChk(cafm_pkg::OFS_FILT_STD + 8'h14, 16'hFFEB);
      wr(cafm_pkg::OFS_MASK_STD + 8'h04, 16'hFFFF);
      rdChk(cafm_pkg::OFS_MASK_STD + 8'h04, 16'hFFEB);
      wr(cafm_pkg::OFS_FILT_EXT + 8'h3C, 16'hA5C3);
      busCycle(1'b1, cafm_pkg::OFS_FILT_EXT + 8'h3C, 16'h1234, 4'h1);
      rdChk(cafm_pkg::OFS_FILT_EXT + 8'h3C, 16'hA534);
      wr(cafm_pkg::OFS_MASK_EXT + 8'h08, 16'h5A5A);
      rdChk(cafm_pkg::OFS_MASK_EXT + 8'h08, 16'h5A5A);
   endtask : checkFields

   task checkStd;
      send(1'b0, 11'h555, 18'h00000, 1'b1, 4'h0, 4'h0);
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFE0);
      wr(cafm_pkg::OFS_FILT_STD, 16'h2460);
      send(1'b0, 11'h123, 18'h00000, 1'b1, 4'h0, 4'h0);
      send(1'b0, 11'h122, 18'h00000, 1'b0, 4'h0, 4'h0);
      send(1'b0, 11'h000, 18'h00000, 1'b1, 4'h1, 4'h0);
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFC0);
      send(1'b0, 11'h122, 18'h00000, 1'b1, 4'h0, 4'h0);
   endtask : checkStd

   task checkExt;
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFE3);
      wr(cafm_pkg::OFS_MASK_EXT, 16'hFFFF);
      wr(cafm_pkg::OFS_FILT_STD, 16'h2462);
      wr(cafm_pkg::OFS_FILT_EXT, 16'hBEEF);
      send(1'b1, 11'h123, 18'h2BEEF, 1'b1, 4'h0, 4'h0);
      send(1'b1, 11'h123, 18'h3BEEF, 1'b0, 4'h0, 4'h0);
      send(1'b1, 11'h123, 18'h2BEEE, 1'b0, 4'h0, 4'h0);
      send(1'b0, 11'h123, 18'h3FFFF, 1'b1, 4'h0, 4'h0);
      wr(cafm_pkg::OFS_MASK_EXT, 16'hFFFE);
      send(1'b1, 11'h123, 18'h2BEEE, 1'b1, 4'h0, 4'h0);
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFE1);
      send(1'b1, 11'h123, 18'h0BEEE, 1'b1, 4'h0, 4'h0);
   endtask : checkExt

   task checkType;
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFE8);
      wr(cafm_pkg::OFS_FILT_STD, 16'h2468);
      send(1'b0, 11'h123, 18'h00000, 1'b0, 4'h0, 4'h0);
      send(1'b1, 11'h123, 18'h00000, 1'b1, 4'h0, 4'h0);
      send(1'b0, 11'h000, 18'h00000, 1'b1, 4'h1, 4'h0);
      send(1'b1, 11'h000, 18'h00000, 1'b0, 4'h0, 4'h0);
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFE0);
      send(1'b0, 11'h123, 18'h00000, 1'b1, 4'h0, 4'h0);
   endtask : checkType

   task checkSelect;
      logic hit;
      wr(cafm_pkg::OFS_FLT_ENABLE, 16'h0200);
      for (int m = 0; m < 3; m++)
         wr(cafm_pkg::OFS_MASK_STD + 8'(4 * m), 16'hFFE0 & ~(16'h0020 << m));
      for (int c = 0; c < 4; c++)
      begin
         wr(cafm_pkg::OFS_MSKSEL_HIGH, 16'(c << 2));
         rdChk(cafm_pkg::OFS_MSKSEL_HIGH, 16'(c << 2));
         for (int b = 0; b < 3; b++)
         begin
            hit = (c == b);
            send(1'b0, 11'h001 << b, 18'h00000, hit, hit ? 4'h9 : 4'h0, 4'h0);
         end
         send(1'b0, 11'h000, 18'h00000, 1'b1, 4'h9, 4'h0);
      end
      wr(cafm_pkg::OFS_FLT_ENABLE, 16'h0080);
      wr(cafm_pkg::OFS_MSKSEL_LOW, 16'h4000);
      send(1'b0, 11'h002, 18'h00000, 1'b1, 4'h7, 4'h0);
      send(1'b0, 11'h001, 18'h00000, 1'b0, 4'h0, 4'h0);
   endtask : checkSelect

   task checkPriority;
      wr(cafm_pkg::OFS_MASK_STD, 16'hFFE0);
      wr(cafm_pkg::OFS_FILT_STD + 8'h0C, 16'h1560);
      wr(cafm_pkg::OFS_FILT_STD + 8'h1C, 16'h1560);
      wr(cafm_pkg::OFS_BUF_PTR, 16'hE000);
      wr(cafm_pkg::OFS_BUF_PTR + 8'h04, 16'hF000);
      send(1'b0, 11'h0AB, 18'h00000, 1'b1, 4'h3, 4'hE);
      rdChk(cafm_pkg::OFS_STATUS, 16'h0E31);
      wr(cafm_pkg::OFS_FLT_ENABLE, 16'hFFF7);
      u_eng.offer(1'b0, 11'h0AB, 18'h00000);
      u_eng.offer(1'b0, 11'h000, 18'h00000);
      res(1'b1, 4'h7, 4'hF);
      u_eng.quiet();
      res(1'b1, 4'h0, 4'h0);
   endtask : checkPriority

   initial
   begin
      doReset();
      checkReset();
      checkFields();
      doReset();
      checkStd();
      doReset();
      checkExt();
      doReset();
      checkType();
      doReset();
      checkSelect();
      doReset();
      checkPriority();
      results();
   end
endmodule : cafm_accept_filter_bench
`default_nettype wire
